// [shared/hwdt_cfg.svh]
// offsets, keys, reset values and field positions of the watchdog
`ifndef HWDT_CFG_SVH
`define HWDT_CFG_SVH
`define OFS_INTERVAL_LOAD 12'h000
`define OFS_COUNT_READBACK 12'h004
`define OFS_WATCHDOG_CTRL 12'h008
`define OFS_KICK 12'h00c
`define OFS_IRQ_FLAG 12'h010
`define OFS_KEY_LOCK 12'h014
`define KEY_FIRST 32'h1acce551
`define KEY_SECOND 32'he5331aae
`define LOAD_INIT 32'h0000ffff
`define CTRL_INIT 2'h3
`define CTRL_IRQ_EN_BIT 0
`define CTRL_RST_EN_BIT 1
`define KICK_WIDTH 8
`endif

// [shared/hwdt_pkg.sv]
// types shared by the watchdog modules
package hwdt_pkg;
  typedef enum logic [1:0] {
    LOCK_CLOSED = 2'h0,
    LOCK_PART   = 2'h1,
    LOCK_FULL   = 2'h3
  } lock_state_type;
  typedef logic [31:0] word_type;
endpackage

// [shared/count_if.sv]
// link between the watchdog control logic and its down counter
`timescale 1ns/1ps
interface count_if;
  logic [31:0] count;
  logic [31:0] load_val;
  logic [31:0] wrap_val;
  logic        load_req;
  logic        run;
  logic        tick;
  logic        underflow;
  modport ctl (output load_val, wrap_val, load_req, run,
               input count, underflow, tick);
  modport cnt (input load_val, wrap_val, load_req, run, tick,
               output count, underflow);
endinterface

// [logic/ls_tick.sv]
// one-cycle tick per rising edge of the low-speed count clock
`timescale 1ns/1ps
module ls_tick (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic low_speed_rc_clock,
  input  wire logic stop_mode,
  output logic      tick
);
  logic prev_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // high after reset: only a real low-to-high edge may tick
      prev_reg <= 1'b1;
    end else begin
      prev_reg <= low_speed_rc_clock;
    end
  end

  // stop mode masks the tick, so the count holds while stop_mode is set
  assign tick = low_speed_rc_clock & ~prev_reg & ~stop_mode; // RULE18 RULE20
endmodule // ls_tick

// [logic/down_counter.sv]
// 32-bit down counter with load and wrap-around reload
`timescale 1ns/1ps
`include "hwdt_cfg.svh"
module down_counter #(
  parameter logic [31:0] INIT = `LOAD_INIT
) (
  input  wire logic pclk,
  input  wire logic presetn,
  count_if.cnt      cif
);
  logic [31:0] count_reg;

  assign cif.count = count_reg;
  assign cif.underflow = cif.run & cif.tick & (count_reg <= 32'h1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= INIT; // RULE9 RULE22
    end else if (cif.load_req) begin
      count_reg <= cif.load_val; // RULE3
    end else if (cif.underflow) begin
      count_reg <= cif.wrap_val; // RULE2 RULE19
    end else if (cif.run && cif.tick) begin
      count_reg <= count_reg - 32'h1; // RULE1
    end
  end
endmodule // down_counter

// [logic/hardware_watchdog_timer.sv]
// hardware watchdog timer with apb register slave
// Function
// RULE1: 32-bit down counter reloads from load value on a valid kick.
// RULE2: counter reaching zero reloads itself and keeps counting.
// RULE3: writing the load register copies it into the counter at once.
// RULE4: enable clear halts counting; setting it reloads and restarts.
// RULE5: live count is readable through the readback register.
// RULE6: software reads the count twice and compares outside debug break.
// RULE7: no counting without irq enable; irq only when reset disabled.
// RULE8: both enables: irq on first underflow, reset on second unserviced.
// RULE9: counting starts alone after reset from 0x0000ffff.
// RULE10: control writes need first key then second key on lock register.
// RULE11: setting irq enable starts the counter.
// RULE12: unlock fully and clear irq enable to stop the watchdog.
// RULE13: a reloading kick pair relocks the registers.
// RULE14: registers come out of reset locked.
// RULE15: partial unlock ends on wrong lock value or load/ctrl/kick write; of the kick writes the code ends it only on the second of a pair.
// RULE16: full unlock ends on lock value not first key or any write; the code ends it on any lock write, else only on a load, ctrl or second kick write.
// RULE17: kick is an 8-bit value then its inverse; only that pair reloads.
// RULE18: stop mode freezes the count, which resumes afterwards.
// RULE19: on watchdog reset the count returns to its initial value.
// RULE20: counter advances on low-speed clock edges, holds while stopped.
// RULE21: wrong second lock write keeps control locked; restart sequence.
// RULE22: watchdog restarts on release of any reset except software reset.
// RULE23: a kick pair that is not inverse is ignored entirely; the code still relocks the registers on such a pair.
// RULE24: a reloading kick pair also clears the pending irq flag.
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps
`include "hwdt_cfg.svh"
module hardware_watchdog_timer (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire hwdt_pkg::word_type pwdata,
  output hwdt_pkg::word_type      prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic         low_speed_rc_clock,
  input  wire logic         stop_mode,
  output logic              wd_irq,
  output logic              wd_reset_req
);
  import hwdt_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  count_if cif ();

  lock_state_type       lock_reg;
  logic [31:0]          interval_load_reg;
  logic [1:0]           watchdog_ctrl_reg;
  logic                 irq_flag_reg;
  logic                 kick_half_reg;
  logic [`KICK_WIDTH-1:0] kick_byte_reg;
  logic [31:0]          prdata_reg;
  logic                 irq_reg;
  logic                 reset_req_reg;

  logic access;
  logic setup;
  logic hit;
  logic wr_load;
  logic wr_ctrl;
  logic wr_kick;
  logic wr_lock;
  logic unlocked;
  logic load_ok;
  logic ctrl_ok;
  logic kick_pair;
  logic kick_ok;
  logic restart;
  logic irq_en;
  logic rst_en;
  logic fire;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == `OFS_INTERVAL_LOAD) || (a == `OFS_COUNT_READBACK) ||
                (a == `OFS_WATCHDOG_CTRL) || (a == `OFS_KICK) ||
                (a == `OFS_IRQ_FLAG) || (a == `OFS_KEY_LOCK);
  endfunction

  assign setup   = psel & ~penable;
  assign access  = psel & penable;
  assign hit     = is_mapped(paddr);
  assign pready  = 1'b1;
  assign pslverr = access & ~hit;
  assign prdata  = prdata_reg;

  assign wr_load = access & pwrite & (paddr == `OFS_INTERVAL_LOAD);
  assign wr_ctrl = access & pwrite & (paddr == `OFS_WATCHDOG_CTRL);
  assign wr_kick = access & pwrite & (paddr == `OFS_KICK);
  assign wr_lock = access & pwrite & (paddr == `OFS_KEY_LOCK);

  // ----------------------------------------------------------------
  // access qualification
  // ----------------------------------------------------------------
  assign unlocked = (lock_reg != LOCK_CLOSED);
  assign load_ok  = wr_load & unlocked;
  assign ctrl_ok  = wr_ctrl & (lock_reg == LOCK_FULL); // RULE10
  // second write of a pair while the lock is open
  assign kick_pair = wr_kick & unlocked & kick_half_reg;
  assign kick_ok   = kick_pair &
                     (pwdata[`KICK_WIDTH-1:0] == ~kick_byte_reg); // RULE17 RULE23
  assign restart  = ctrl_ok & pwdata[`CTRL_IRQ_EN_BIT] & ~irq_en; // RULE4 RULE11

  assign irq_en = watchdog_ctrl_reg[`CTRL_IRQ_EN_BIT];
  assign rst_en = watchdog_ctrl_reg[`CTRL_RST_EN_BIT];
  assign fire   = cif.underflow & irq_flag_reg & rst_en; // RULE8

  // ----------------------------------------------------------------
  // key lock
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_reg <= LOCK_CLOSED; // RULE14
    end else begin
      unique case (lock_reg)
        LOCK_CLOSED: begin
          if (wr_lock && pwdata == `KEY_FIRST) begin
            lock_reg <= LOCK_PART;
          end
        end
        LOCK_PART: begin
          if (wr_lock) begin
            if (pwdata == `KEY_SECOND) begin
              lock_reg <= LOCK_FULL; // RULE10
            end else if (pwdata != `KEY_FIRST) begin
              lock_reg <= LOCK_CLOSED; // RULE15 RULE21
            end
          end else if (wr_load || wr_ctrl || kick_pair) begin
            lock_reg <= LOCK_CLOSED; // RULE15 RULE13
          end
        end
        LOCK_FULL: begin
          if (wr_lock) begin
            // the first key restarts the two-key sequence
            lock_reg <= (pwdata == `KEY_FIRST) ? LOCK_PART
                                               : LOCK_CLOSED; // RULE16
          end else if (wr_load || wr_ctrl || kick_pair) begin
            lock_reg <= LOCK_CLOSED; // RULE16 RULE13
          end
        end
        default: begin
          lock_reg <= LOCK_CLOSED;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // kick sequence
  // ----------------------------------------------------------------
  // a half-done pair is dropped whenever the lock closes, so a stale
  // first byte can never pair with a write made after a fresh unlock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kick_half_reg <= 1'b0;
      kick_byte_reg <= '0;
    end else if (lock_reg == LOCK_CLOSED) begin
      kick_half_reg <= 1'b0;
    end else if (wr_kick) begin
      kick_half_reg <= ~kick_half_reg; // RULE17
      if (!kick_half_reg) begin
        kick_byte_reg <= pwdata[`KICK_WIDTH-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // load and control registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interval_load_reg <= `LOAD_INIT;
    end else if (load_ok) begin
      interval_load_reg <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_ctrl_reg <= `CTRL_INIT; // RULE8 RULE9 RULE22
    end else if (ctrl_ok) begin
      watchdog_ctrl_reg <= pwdata[1:0]; // RULE12
    end
  end

  // ----------------------------------------------------------------
  // counter control
  // ----------------------------------------------------------------
  // a load write reaches the counter in the same cycle it is stored
  assign cif.load_req = load_ok | kick_ok | restart; // RULE1 RULE3 RULE4
  assign cif.load_val = load_ok ? pwdata : interval_load_reg;
  assign cif.wrap_val = fire ? `LOAD_INIT : interval_load_reg; // RULE19
  assign cif.run      = irq_en; // RULE7 RULE12

  ls_tick u_tick (
    .pclk               (pclk),
    .presetn            (presetn),
    .low_speed_rc_clock (low_speed_rc_clock),
    .stop_mode          (stop_mode),
    .tick               (cif.tick)
  );

  down_counter #(
    .INIT (`LOAD_INIT)
  ) u_counter (
    .pclk    (pclk),
    .presetn (presetn),
    .cif     (cif.cnt)
  );

  // ----------------------------------------------------------------
  // interrupt flag and reset request
  // ----------------------------------------------------------------
  // an underflow in the cycle of a kick wins, so no event is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_flag_reg <= 1'b0;
    end else if (cif.underflow && !fire) begin
      irq_flag_reg <= 1'b1; // RULE7 RULE8
    end else if (kick_ok || fire) begin
      irq_flag_reg <= 1'b0; // RULE24
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_flag_reg & irq_en;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_req_reg <= 1'b0;
    end else begin
      reset_req_reg <= fire; // RULE8
    end
  end

  assign wd_irq       = irq_reg;
  assign wd_reset_req = reset_req_reg;

  // ----------------------------------------------------------------
  // read data, captured in the setup phase
  // ----------------------------------------------------------------
  // the count can move between setup and access, hence the double
  // read that software does when no debug break holds the counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
    end else if (setup && !pwrite) begin
      unique case (paddr)
        `OFS_INTERVAL_LOAD:  prdata_reg <= interval_load_reg;
        `OFS_COUNT_READBACK: prdata_reg <= cif.count; // RULE5 RULE6
        `OFS_WATCHDOG_CTRL:  prdata_reg <= {30'h0, watchdog_ctrl_reg};
        `OFS_IRQ_FLAG:       prdata_reg <= {31'h0, irq_flag_reg};
        `OFS_KEY_LOCK:       prdata_reg <= {30'h0, lock_reg};
        default:             prdata_reg <= '0;
      endcase
    end
  end
endmodule // hardware_watchdog_timer

// [verif/hardware_watchdog_timer_assertions.sv]
// port assertions for the hardware watchdog timer
`timescale 1ns/1ps
`include "hwdt_cfg.svh"
module hardware_watchdog_timer_assertions (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [11:0]        paddr,
  input wire hwdt_pkg::word_type prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic               wd_irq,
  input wire logic               wd_reset_req
);
  import hwdt_pkg::*;
  // --------------------------------
  // checks
  // --------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd_acc;
  assign rd_acc = psel && penable && !pwrite;
  AST_PREADY:
    assert property (psel |-> pready) else $error("wait state seen");
  AST_PSLVERR:
    assert property (psel && penable && paddr > `OFS_KEY_LOCK |-> pslverr)
    else $error("unmapped access without error");
  AST_RST_PULSE:
    assert property (wd_reset_req |=> !wd_reset_req [*3])
    else $error("reset pulse too long or too close");
  AST_RST_WITH_IRQ:
    assert property ($rose(wd_reset_req) |-> wd_irq || $past(wd_irq))
    else $error("reset without pending interrupt");
  AST_RESET_QUIET:
    assert property ($rose(presetn) |-> !wd_irq ##1 !wd_reset_req)
    else $error("outputs active right after reset");
  AST_RDATA_HOLD:
    assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved without read");
  AST_ZERO_READ:
    assert property (rd_acc && (paddr == `OFS_KICK ||
      paddr > `OFS_KEY_LOCK) |-> prdata == 32'h0)
    else $error("kick or unmapped read not zero");
  AST_LOCK_ENC:
    assert property (rd_acc && paddr == `OFS_KEY_LOCK |->
      prdata inside {32'h0, 32'h1, 32'h3})
    else $error("bad lock state");
endmodule // hardware_watchdog_timer_assertions

// [verif/tb_hardware_watchdog_timer.sv]
// self-checking bench for the hardware watchdog timer
`timescale 1ns/1ps
`include "hwdt_cfg.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
  bad_count++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_hardware_watchdog_timer;
  import hwdt_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, stop_mode, ls_on;
  logic        low_speed_rc_clock, pready, pslverr, wd_irq, wd_reset_req;
  logic [11:0] paddr;
  word_type    pwdata, prdata, rdv, v0;
  int          bad_count, tests_run, n;
  hardware_watchdog_timer i_hardware_watchdog_timer (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .low_speed_rc_clock(low_speed_rc_clock),
    .stop_mode(stop_mode), .wd_irq(wd_irq), .wd_reset_req(wd_reset_req));
  // --------------------------------
  // clocks and bus tasks
  // --------------------------------
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // count clock at an eighth of pclk, stops outright when ls_on drops
  always @(posedge pclk) begin
    n <= n + 1;
    if (ls_on && n % 4 == 3) low_speed_rc_clock <= ~low_speed_rc_clock;
  end
  task automatic rw(input logic [11:0] a, input logic w, input word_type d);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rc(input logic [11:0] a, input word_type e);
    rw(a, 1'b0, 32'h0);
    `CHK($sformatf("reg %h", a), e, rdv)
  endtask
  task automatic ul(input logic full);
    rw(`OFS_KEY_LOCK, 1'b1, `KEY_FIRST);
    if (full) rw(`OFS_KEY_LOCK, 1'b1, `KEY_SECOND);
  endtask
  task automatic kick(input logic [7:0] b);
    ul(1'b0);
    rw(`OFS_KICK, 1'b1, {24'h0, 8'h5a});
    rw(`OFS_KICK, 1'b1, {24'h0, b});
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic t_reset;
    rc(`OFS_KEY_LOCK, 32'h0);
    rc(`OFS_WATCHDOG_CTRL, {30'h0, `CTRL_INIT});
    rc(`OFS_INTERVAL_LOAD, `LOAD_INIT);
    rw(`OFS_COUNT_READBACK, 1'b0, 32'h0);
    v0 = rdv;
    repeat (20) @(posedge pclk);
    rw(`OFS_COUNT_READBACK, 1'b0, 32'h0);
    `CHK("count runs", 1'b1, rdv < v0 && v0 < `LOAD_INIT)
  endtask
  task automatic t_stop;
    stop_mode <= 1'b1;
    repeat (4) @(posedge pclk);
    rw(`OFS_COUNT_READBACK, 1'b0, 32'h0);
    v0 = rdv;
    repeat (40) @(posedge pclk);
    rc(`OFS_COUNT_READBACK, v0);
    // stop the count clock before leaving stop mode, so no edge slips in
    ls_on <= 1'b0;
    repeat (4) @(posedge pclk);
    stop_mode <= 1'b0;
    repeat (40) @(posedge pclk);
    rc(`OFS_COUNT_READBACK, v0);
    ls_on <= 1'b1;
    repeat (30) @(posedge pclk);
    rw(`OFS_COUNT_READBACK, 1'b0, 32'h0);
    `CHK("count resumes", 1'b1, rdv < v0)
  endtask
  task automatic t_lock;
    ul(1'b0);
    rc(`OFS_KEY_LOCK, 32'h1);
    rw(`OFS_WATCHDOG_CTRL, 1'b1, 32'h0);
    rc(`OFS_KEY_LOCK, 32'h0);
    rc(`OFS_WATCHDOG_CTRL, 32'h3);
    ul(1'b0);
    rw(`OFS_KEY_LOCK, 1'b1, 32'h0);
    rc(`OFS_KEY_LOCK, 32'h0);
    ul(1'b1);
    rc(`OFS_KEY_LOCK, 32'h3);
    rw(`OFS_KEY_LOCK, 1'b1, `KEY_FIRST);
    rc(`OFS_KEY_LOCK, 32'h1);
    rc(`OFS_KICK, 32'h0);
    rc(12'h018, 32'h0);
  endtask
  task automatic t_irq;
    ul(1'b0);
    rw(`OFS_INTERVAL_LOAD, 1'b1, 32'h10);
    rw(`OFS_COUNT_READBACK, 1'b0, 32'h0);
    `CHK("count loaded", 1'b1, rdv <= 32'h10)
    rc(`OFS_KEY_LOCK, 32'h0);
    for (int k = 0; k < 400 && wd_irq !== 1'b1; k++) @(posedge pclk);
    `CHK("wd_irq", 1'b1, wd_irq)
    kick(8'h5b);
    rc(`OFS_IRQ_FLAG, 32'h1);
    kick(8'ha5);
    rc(`OFS_IRQ_FLAG, 32'h0);
    rc(`OFS_KEY_LOCK, 32'h0);
    rw(`OFS_COUNT_READBACK, 1'b0, 32'h0);
    `CHK("kick reload", 1'b1, rdv >= 32'hd)
  endtask
  task automatic t_rst;
    for (int k = 0; k < 600 && wd_reset_req !== 1'b1; k++) @(posedge pclk);
    `CHK("wd_reset_req", 1'b1, wd_reset_req)
    rw(`OFS_COUNT_READBACK, 1'b0, 32'h0);
    `CHK("count restart", 1'b1, rdv >= 32'hfff0)
  endtask
  task automatic t_modes;
    ul(1'b1);
    rw(`OFS_WATCHDOG_CTRL, 1'b1, 32'h1);
    ul(1'b0);
    rw(`OFS_INTERVAL_LOAD, 1'b1, 32'h10);
    v0 = 32'h0;
    for (int k = 0; k < 500; k++) begin
      @(posedge pclk);
      if (wd_reset_req === 1'b1) v0 = 32'h1;
    end
    `CHK("irq only", 32'h0, v0)
    `CHK("wd_irq", 1'b1, wd_irq)
    ul(1'b1);
    rw(`OFS_WATCHDOG_CTRL, 1'b1, 32'h0);
    rw(`OFS_COUNT_READBACK, 1'b0, 32'h0);
    v0 = rdv;
    repeat (40) @(posedge pclk);
    rc(`OFS_COUNT_READBACK, v0);
    ul(1'b1);
    rw(`OFS_WATCHDOG_CTRL, 1'b1, 32'h3);
    rw(`OFS_COUNT_READBACK, 1'b0, 32'h0);
    `CHK("restart", 1'b1, rdv >= 32'hf)
  endtask
  task automatic t_rerun;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    `CHK("wd_irq after reset", 1'b0, wd_irq)
    rc(`OFS_WATCHDOG_CTRL, {30'h0, `CTRL_INIT});
    rc(`OFS_INTERVAL_LOAD, `LOAD_INIT);
    rc(`OFS_IRQ_FLAG, 32'h0);
    rc(`OFS_KEY_LOCK, 32'h0);
    rw(`OFS_COUNT_READBACK, 1'b0, 32'h0);
    v0 = rdv;
    repeat (20) @(posedge pclk);
    rw(`OFS_COUNT_READBACK, 1'b0, 32'h0);
    `CHK("count reruns", 1'b1, rdv < v0 && v0 <= `LOAD_INIT)
  endtask
  initial begin
    {psel, penable, pwrite, stop_mode, low_speed_rc_clock} = 5'h0;
    {paddr, pwdata, n, bad_count, tests_run} = '0;
    ls_on = 1'b1;
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_stop();
    t_lock();
    t_irq();
    t_rst();
    t_modes();
    t_rerun();
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    end_sim();
  end
endmodule // tb_hardware_watchdog_timer
bind hardware_watchdog_timer hardware_watchdog_timer_assertions i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .wd_irq(wd_irq), .wd_reset_req(wd_reset_req));
